/* File: ucse_map.svh */
// constants of the ulpi command and status byte exchange
`ifndef UCSE_MAP_SVH
`define UCSE_MAP_SVH

`define UCSE_IDLE_BYTE 8'h00
`define UCSE_CODE_IDLE 2'h0
`define UCSE_CODE_TX 2'h1
`define UCSE_CODE_WR 2'h2
`define UCSE_CODE_RD 2'h3
`define UCSE_RAW_PAYLOAD 6'h00
`define UCSE_EXT_PAYLOAD 6'h2F
`define UCSE_SHORT_ADDR_MAX 8'h3F

`define UCSE_VBUS_BELOW_END 2'h0
`define UCSE_VBUS_END_TO_VALID 2'h1
`define UCSE_VBUS_VALID 2'h2
`define UCSE_VBUS_A_OK 2'h3

`define UCSE_EVT_NONE 2'h0
`define UCSE_EVT_ACTIVE 2'h1
`define UCSE_EVT_ERROR 2'h3
`define UCSE_EVT_DISCONNECT 2'h2

`define UCSE_STAT_EVT_MSB 5
`define UCSE_STAT_EVT_LSB 4
`define UCSE_BOOT_PEND_RST 1'h1

`endif

/* File: ucse_pkg.sv */
// types shared by both ends of the ulpi command and status exchange
package ucse_pkg;

  typedef enum logic [1:0] {
    UCSE_KIND_RAW = 2'h0,
    UCSE_KIND_PID = 2'h1,
    UCSE_KIND_WR = 2'h2,
    UCSE_KIND_RD = 2'h3
  } ucse_kind_t;

  typedef struct packed {
    logic [1:0] linestate;
    logic session_ended_flag;
    logic session_valid_flag;
    logic a_device_supply_ok;
    logic rx_active;
    logic rx_error;
    logic host_disconnect;
    logic cable_identification_level;
    logic b_valid;
    logic alt_rise_en;
    logic alt_fall_en;
    logic low_power;
  } ucse_phy_in_t;

  typedef enum logic [8:0] {
    PH_IDLE = 9'h001,
    PH_CMD = 9'h002,
    PH_TXD = 9'h004,
    PH_ADDR = 9'h008,
    PH_WDATA = 9'h010,
    PH_RTURN = 9'h020,
    PH_RDATA = 9'h040,
    PH_STURN = 9'h080,
    PH_STAT = 9'h100
  } ucse_phy_state_t;

  typedef enum logic [5:0] {
    LK_IDLE = 6'h01,
    LK_CMD = 6'h02,
    LK_STP = 6'h04,
    LK_RDT = 6'h08,
    LK_RDD = 6'h10,
    LK_RX = 6'h20
  } ucse_link_state_t;

endpackage

/* File: ucse_ulpi_if.sv */
// ulpi bus between the transceiver end and the link end
`timescale 1ns/100ps
interface ucse_ulpi_if (
  input wire logic ulpi_clk
);
  logic dir;
  logic nxt;
  logic stp;
  logic [7:0] link_dout;
  logic link_doe_n;
  logic [7:0] phy_dout;
  logic phy_doe_n;
  logic [7:0] data;

  // undriven bus reads as idle, as the pull-downs would leave it
  assign data = !phy_doe_n ? phy_dout : (!link_doe_n ? link_dout : 8'h00);

  modport phy (
    input ulpi_clk,
    input stp,
    input data,
    output dir,
    output nxt,
    output phy_dout,
    output phy_doe_n
  );

  modport link (
    input ulpi_clk,
    input dir,
    input nxt,
    input data,
    output stp,
    output link_dout,
    output link_doe_n
  );
endinterface

/* File: ucse_phy_end.sv */
// transceiver end: command decode and receive status byte sender
// How it works
// RQ1 - link idles the bus at zero
// RQ2 - nonzero command, nxt accepts, then data follows
// RQ3 - link sends only defined command bytes
// RQ4 - raw transmit starts with next byte
// RQ5 - packet transmit takes pid from low nibble
// RQ6 - extended write: address byte then data
// RQ7 - short write uses six-bit payload address
// RQ8 - extended read: address byte follows command
// RQ9 - short read uses six-bit payload address
// RQ10 - status sent with dir high, one byte
// RQ11 - any field change sends new status
// RQ12 - link accepts status bytes at any time
// RQ13 - status may be skipped after low power
// RQ14 - bits 1:0 carry line state
// RQ15 - bits 3:2 carry vbus level code
// RQ16 - bits 5:4 carry receive event code
// RQ17 - bit 6 follows cable identification level
// RQ18 - bit 7 flags enabled b-valid edges
// RQ19 - one status byte after every reset
// RQ20 - receive active by dir+nxt or status
// RQ21 - link holds command until nxt
`timescale 1ns/100ps
`include "ucse_map.svh"
module ucse_phy_end (
  ucse_ulpi_if.phy ulpi,
  input wire logic arst_n,
  input wire logic [1:0] linestate,
  input wire logic session_ended_flag,
  input wire logic session_valid_flag,
  input wire logic a_device_supply_ok,
  input wire logic rx_active,
  input wire logic rx_error,
  input wire logic host_disconnect,
  input wire logic cable_identification_level,
  input wire logic b_valid,
  input wire logic alt_rise_en,
  input wire logic alt_fall_en,
  input wire logic low_power,
  input wire logic [7:0] reg_rdata,
  output logic tx_start,
  output logic tx_raw,
  output logic [3:0] tx_pid,
  output logic tx_byte_valid,
  output logic [7:0] tx_byte,
  output logic tx_end,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    ucse_pkg::ucse_phy_state_t st;
    ucse_pkg::ucse_phy_in_t sync1;
    ucse_pkg::ucse_phy_in_t sync2;
    logic bv_prev;
    logic boot_pend;
    logic alt_pend;
    logic [6:0] last_sent;
    logic [7:0] cmd;
    logic first;
    logic dir;
    logic nxt;
    logic [7:0] dout;
    logic doe_n;
    logic tx_start;
    logic tx_raw;
    logic [3:0] tx_pid;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic tx_end;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
  } ucse_phy_q_t;

  ucse_phy_q_t q;
  ucse_phy_q_t n;
  ucse_pkg::ucse_phy_in_t pins;
  ucse_pkg::ucse_phy_in_t s;
  logic [1:0] vbus_code;
  logic [1:0] evt_code;
  logic [6:0] cur;
  logic [7:0] stat_b;
  logic pending;
  logic load_stat;

  assign pins = '{
    linestate: linestate,
    session_ended_flag: session_ended_flag,
    session_valid_flag: session_valid_flag,
    a_device_supply_ok: a_device_supply_ok,
    rx_active: rx_active,
    rx_error: rx_error,
    host_disconnect: host_disconnect,
    cable_identification_level: cable_identification_level,
    b_valid: b_valid,
    alt_rise_en: alt_rise_en,
    alt_fall_en: alt_fall_en,
    low_power: low_power
  };
  assign s = q.sync2;

  // ********************************************************
  // status byte fields
  // ********************************************************
  // vbus: highest threshold reached wins
  assign vbus_code = s.a_device_supply_ok ? `UCSE_VBUS_A_OK :
                     s.session_valid_flag ? `UCSE_VBUS_VALID :
                     !s.session_ended_flag ? `UCSE_VBUS_END_TO_VALID :
                     `UCSE_VBUS_BELOW_END; // [RQ15]
  // disconnect outranks receive flags, error needs active
  assign evt_code = s.host_disconnect ? `UCSE_EVT_DISCONNECT :
                    !s.rx_active ? `UCSE_EVT_NONE :
                    s.rx_error ? `UCSE_EVT_ERROR : `UCSE_EVT_ACTIVE; // [RQ16]
  assign cur = {s.cable_identification_level, evt_code, vbus_code, s.linestate}; // [RQ14] [RQ17]
  assign stat_b = {q.alt_pend, cur}; // [RQ18]
  // live compare, so a change undone during low power sends nothing
  assign pending = q.boot_pend | q.alt_pend | (cur != q.last_sent); // [RQ11] [RQ13] [RQ19]

  // ********************************************************
  // next state
  // ********************************************************
  always_comb
  begin
    n = q;
    load_stat = 1'h0;
    n.sync1 = pins;
    n.sync2 = q.sync1;
    n.bv_prev = s.b_valid;
    n.tx_start = 1'h0;
    n.tx_valid = 1'h0;
    n.tx_end = 1'h0;
    n.reg_wr = 1'h0;
    n.reg_rd = 1'h0;
    unique case (q.st)
      ucse_pkg::PH_IDLE:
      begin
        // a command on the bus outranks a waiting status byte
        if (ulpi.data != `UCSE_IDLE_BYTE && !ulpi.stp)
        begin
          n.cmd = ulpi.data;
          n.nxt = 1'h1; // [RQ2]
          n.st = ucse_pkg::PH_CMD;
        end
        else if (pending && !s.low_power)
        begin
          n.dir = 1'h1; // [RQ10]
          n.st = ucse_pkg::PH_STURN;
        end
      end
      ucse_pkg::PH_CMD:
      begin
        unique case (q.cmd[7:6])
          `UCSE_CODE_TX:
          begin
            if (q.cmd[5:0] == `UCSE_RAW_PAYLOAD)
            begin
              n.tx_raw = 1'h1;
              n.first = 1'h1; // [RQ4]
              n.st = ucse_pkg::PH_TXD;
            end
            else if (q.cmd[5:4] == 2'h0)
            begin
              n.tx_raw = 1'h0;
              n.tx_pid = q.cmd[3:0];
              n.tx_start = 1'h1; // [RQ5]
              n.st = ucse_pkg::PH_TXD;
            end
            else
            begin
              // undefined code: drop it and free the bus
              n.nxt = 1'h0;
              n.st = ucse_pkg::PH_IDLE;
            end
          end
          `UCSE_CODE_WR:
          begin
            if (q.cmd[5:0] == `UCSE_EXT_PAYLOAD)
            begin
              n.st = ucse_pkg::PH_ADDR; // [RQ6]
            end
            else
            begin
              n.reg_addr = {2'h0, q.cmd[5:0]}; // [RQ7]
              n.st = ucse_pkg::PH_WDATA;
            end
          end
          `UCSE_CODE_RD:
          begin
            if (q.cmd[5:0] == `UCSE_EXT_PAYLOAD)
            begin
              n.st = ucse_pkg::PH_ADDR; // [RQ8]
            end
            else
            begin
              n.reg_addr = {2'h0, q.cmd[5:0]}; // [RQ9]
              n.reg_rd = 1'h1;
              n.nxt = 1'h0;
              n.dir = 1'h1;
              n.st = ucse_pkg::PH_RTURN;
            end
          end
          `UCSE_CODE_IDLE:
          begin
            n.nxt = 1'h0;
            n.st = ucse_pkg::PH_IDLE;
          end
        endcase
      end
      ucse_pkg::PH_TXD:
      begin
        if (ulpi.stp)
        begin
          n.nxt = 1'h0;
          n.tx_end = 1'h1;
          n.st = ucse_pkg::PH_IDLE;
        end
        else
        begin
          n.tx_valid = 1'h1;
          n.tx_byte = ulpi.data;
          n.first = 1'h0;
          n.tx_start = q.first & q.tx_raw; // [RQ4]
        end
      end
      ucse_pkg::PH_ADDR:
      begin
        n.reg_addr = ulpi.data; // [RQ6] [RQ8]
        if (q.cmd[6])
        begin
          n.reg_rd = 1'h1;
          n.nxt = 1'h0;
          n.dir = 1'h1;
          n.st = ucse_pkg::PH_RTURN;
        end
        else
        begin
          n.st = ucse_pkg::PH_WDATA;
        end
      end
      ucse_pkg::PH_WDATA:
      begin
        n.reg_wdata = ulpi.data;
        n.reg_wr = 1'h1;
        n.nxt = 1'h0;
        n.st = ucse_pkg::PH_IDLE;
      end
      ucse_pkg::PH_RTURN:
      begin
        // turnaround done, user had one cycle to present the value
        n.dout = reg_rdata;
        n.doe_n = 1'h0;
        n.st = ucse_pkg::PH_RDATA;
      end
      ucse_pkg::PH_RDATA:
      begin
        n.dir = 1'h0;
        n.doe_n = 1'h1;
        n.st = ucse_pkg::PH_IDLE;
      end
      ucse_pkg::PH_STURN:
      begin
        load_stat = 1'h1; // [RQ10]
        n.st = ucse_pkg::PH_STAT;
      end
      ucse_pkg::PH_STAT:
      begin
        if (pending && !s.low_power)
        begin
          load_stat = 1'h1; // [RQ11]
        end
        else
        begin
          n.dir = 1'h0;
          n.doe_n = 1'h1;
          n.st = ucse_pkg::PH_IDLE;
        end
      end
      default:
      begin
        n.dir = 1'h0;
        n.nxt = 1'h0;
        n.doe_n = 1'h1;
        n.st = ucse_pkg::PH_IDLE;
      end
    endcase
    if (load_stat)
    begin
      n.dout = stat_b;
      n.doe_n = 1'h0;
      n.last_sent = cur;
      n.boot_pend = 1'h0;
      n.alt_pend = 1'h0;
    end
    // an edge seen while sending still sets the flag
    if ((s.alt_rise_en && s.b_valid && !q.bv_prev) ||
        (s.alt_fall_en && !s.b_valid && q.bv_prev))
    begin
      n.alt_pend = 1'h1; // [RQ18]
    end
  end

  always_ff @(posedge ulpi.ulpi_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
      q.st <= ucse_pkg::PH_IDLE;
      q.doe_n <= 1'h1;
      q.boot_pend <= `UCSE_BOOT_PEND_RST; // [RQ19]
    end
    else
    begin
      q <= n;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign ulpi.dir = q.dir;
  assign ulpi.nxt = q.nxt;
  assign ulpi.phy_dout = q.dout;
  assign ulpi.phy_doe_n = q.doe_n;
  assign tx_start = q.tx_start;
  assign tx_raw = q.tx_raw;
  assign tx_pid = q.tx_pid;
  assign tx_byte_valid = q.tx_valid;
  assign tx_byte = q.tx_byte;
  assign tx_end = q.tx_end;
  assign reg_wr = q.reg_wr;
  assign reg_rd = q.reg_rd;
  assign reg_addr = q.reg_addr;
  assign reg_wdata = q.reg_wdata;

endmodule

/* File: ucse_link_end.sv */
// link end: sends command bytes, receives status bytes
`timescale 1ns/100ps
`include "ucse_map.svh"
module ucse_link_end (
  ucse_ulpi_if.link ulpi,
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire ucse_pkg::ucse_kind_t req_kind,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_data,
  output logic req_ready,
  output logic done,
  output logic [7:0] rd_data,
  output logic status_valid,
  output logic [7:0] status_byte,
  output logic rx_active
);

  // ********************************************************
  // state of both domains
  // ********************************************************
  typedef struct packed {
    ucse_pkg::ucse_link_state_t st;
    logic [1:0] idx;
    logic [7:0] dout;
    logic doe_n;
    logic stp;
    logic req_s1;
    logic req_s2;
    logic ack_tgl;
    logic [7:0] rdata_h;
    logic sack_s1;
    logic sack_s2;
    logic stat_tgl;
    logic [7:0] stat_word;
    logic stat_pend;
    logic [7:0] stat_new;
    logic rx_act;
  } ucse_lk_q_t;

  typedef struct packed {
    logic req_tgl;
    logic [2:0][7:0] bytes;
    logic [1:0] n_bytes;
    logic is_rd;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic ready;
    logic done;
    logic [7:0] rd_data;
    logic stat_s1;
    logic stat_s2;
    logic stat_seen;
    logic status_valid;
    logic [7:0] status_byte;
    logic rxa_s1;
    logic rxa_s2;
  } ucse_rf_q_t;

  ucse_lk_q_t lq;
  ucse_lk_q_t ln;
  ucse_rf_q_t rq;
  ucse_rf_q_t rn;
  logic busy;
  logic ext_addr;
  logic [1:0] idx_inc;

  // words from the other domain are read only while its toggle says they stand still
  assign busy = lq.req_s2 != lq.ack_tgl;
  assign ext_addr = (req_addr > `UCSE_SHORT_ADDR_MAX) || (req_addr[5:0] == `UCSE_EXT_PAYLOAD);
  assign idx_inc = lq.idx + 2'h1;

  // ********************************************************
  // bus side, link clock
  // ********************************************************
  always_comb
  begin
    ln = lq;
    ln.req_s1 = rq.req_tgl;
    ln.req_s2 = lq.req_s1;
    ln.sack_s1 = rq.stat_seen;
    ln.sack_s2 = lq.sack_s1;
    ln.stp = 1'h0;
    if (lq.stat_pend && lq.stat_tgl == lq.sack_s2)
    begin
      ln.stat_word = lq.stat_new;
      ln.stat_tgl = ~lq.stat_tgl;
      ln.stat_pend = 1'h0;
    end
    unique case (lq.st)
      ucse_pkg::LK_IDLE:
      begin
        ln.dout = `UCSE_IDLE_BYTE; // [RQ1]
        if (ulpi.dir)
        begin
          ln.doe_n = 1'h1;
          ln.rx_act = ulpi.nxt ? 1'h1 : lq.rx_act; // [RQ20]
          ln.st = ucse_pkg::LK_RX;
        end
        else if (busy)
        begin
          ln.dout = rq.bytes[0]; // [RQ2] [RQ3]
          ln.idx = 2'h0;
          ln.st = ucse_pkg::LK_CMD;
        end
      end
      ucse_pkg::LK_CMD:
      begin
        if (ulpi.dir && !ulpi.nxt)
        begin
          // transceiver took the bus first; retry after it is done
          ln.doe_n = 1'h1;
          ln.st = ucse_pkg::LK_RX;
        end
        else if (ulpi.nxt)
        begin
          ln.idx = idx_inc; // [RQ2]
          if (idx_inc == rq.n_bytes && rq.is_rd)
          begin
            ln.doe_n = 1'h1;
            ln.st = ucse_pkg::LK_RDT;
          end
          else if (idx_inc == rq.n_bytes)
          begin
            ln.dout = `UCSE_IDLE_BYTE;
            ln.stp = 1'h1;
            ln.st = ucse_pkg::LK_STP;
          end
          else
          begin
            ln.dout = rq.bytes[idx_inc];
          end
        end
        // without nxt the byte simply stays on the bus [RQ21]
      end
      ucse_pkg::LK_STP:
      begin
        ln.ack_tgl = ~lq.ack_tgl;
        ln.st = ucse_pkg::LK_IDLE;
      end
      ucse_pkg::LK_RDT:
      begin
        if (ulpi.dir)
        begin
          ln.st = ucse_pkg::LK_RDD;
        end
      end
      ucse_pkg::LK_RDD:
      begin
        ln.rdata_h = ulpi.data;
        ln.ack_tgl = ~lq.ack_tgl;
        ln.st = ucse_pkg::LK_RX;
      end
      ucse_pkg::LK_RX:
      begin
        if (!ulpi.dir)
        begin
          // receive ends with dir low at the latest
          ln.rx_act = 1'h0;
          ln.doe_n = 1'h0;
          ln.dout = `UCSE_IDLE_BYTE;
          ln.st = ucse_pkg::LK_IDLE;
        end
        else if (ulpi.nxt)
        begin
          ln.rx_act = 1'h1; // [RQ20]
        end
        else
        begin
          ln.stat_new = ulpi.data; // [RQ12]
          ln.stat_pend = 1'h1;
          ln.rx_act = ulpi.data[`UCSE_STAT_EVT_LSB] &
                      (ulpi.data[`UCSE_STAT_EVT_MSB:`UCSE_STAT_EVT_LSB] != `UCSE_EVT_DISCONNECT);
        end
      end
      default:
      begin
        ln.doe_n = 1'h1;
        ln.st = ucse_pkg::LK_RX;
      end
    endcase
  end

  always_ff @(posedge ulpi.ulpi_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lq <= '0;
      lq.st <= ucse_pkg::LK_IDLE;
    end
    else
    begin
      lq <= ln;
    end
  end

  // ********************************************************
  // user side, reference clock
  // ********************************************************
  always_comb
  begin
    rn = rq;
    rn.ack_s1 = lq.ack_tgl;
    rn.ack_s2 = rq.ack_s1;
    rn.stat_s1 = lq.stat_tgl;
    rn.stat_s2 = rq.stat_s1;
    rn.rxa_s1 = lq.rx_act;
    rn.rxa_s2 = rq.rxa_s1;
    rn.done = 1'h0;
    rn.status_valid = 1'h0;
    if (rq.ready && req_valid)
    begin
      rn.ready = 1'h0;
      rn.req_tgl = ~rq.req_tgl;
      rn.is_rd = req_kind == ucse_pkg::UCSE_KIND_RD;
      rn.bytes = '0;
      unique case (req_kind)
        ucse_pkg::UCSE_KIND_RAW:
        begin
          rn.bytes[0] = {`UCSE_CODE_TX, `UCSE_RAW_PAYLOAD};
          rn.bytes[1] = req_data;
          rn.n_bytes = 2'h2;
        end
        ucse_pkg::UCSE_KIND_PID:
        begin
          rn.bytes[0] = {`UCSE_CODE_TX, 2'h0, req_addr[3:0]};
          rn.bytes[1] = req_data;
          rn.n_bytes = 2'h2;
        end
        ucse_pkg::UCSE_KIND_WR:
        begin
          rn.bytes[0] = {`UCSE_CODE_WR, ext_addr ? `UCSE_EXT_PAYLOAD : req_addr[5:0]};
          rn.bytes[1] = ext_addr ? req_addr : req_data;
          rn.bytes[2] = req_data;
          rn.n_bytes = ext_addr ? 2'h3 : 2'h2;
        end
        ucse_pkg::UCSE_KIND_RD:
        begin
          rn.bytes[0] = {`UCSE_CODE_RD, ext_addr ? `UCSE_EXT_PAYLOAD : req_addr[5:0]};
          rn.bytes[1] = req_addr;
          rn.n_bytes = ext_addr ? 2'h2 : 2'h1;
        end
      endcase
    end
    if (rq.ack_s2 != rq.ack_seen)
    begin
      rn.ack_seen = rq.ack_s2;
      rn.done = 1'h1;
      rn.rd_data = lq.rdata_h;
      rn.ready = 1'h1;
    end
    if (rq.stat_s2 != rq.stat_seen)
    begin
      rn.stat_seen = rq.stat_s2;
      rn.status_valid = 1'h1;
      rn.status_byte = lq.stat_word;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rq <= '0;
      rq.ready <= 1'h1;
    end
    else
    begin
      rq <= rn;
    end
  end

  assign ulpi.link_dout = lq.dout;
  assign ulpi.link_doe_n = lq.doe_n;
  assign ulpi.stp = lq.stp;
  assign req_ready = rq.ready;
  assign done = rq.done;
  assign rd_data = rq.rd_data;
  assign status_valid = rq.status_valid;
  assign status_byte = rq.status_byte;
  assign rx_active = rq.rxa_s2;

endmodule

/* File: ucse_monitor.sv */
// checker of the ulpi bus between the two ends
`timescale 1ns/100ps
module ucse_monitor (
  input wire logic ulpi_clk,
  input wire logic arst_n,
  input wire logic dir,
  input wire logic nxt,
  input wire logic stp,
  input wire logic [7:0] link_dout,
  input wire logic link_doe_n,
  input wire logic [7:0] phy_dout,
  input wire logic phy_doe_n,
  input wire logic [7:0] data
);
  default clocking mon_cb @(posedge ulpi_clk);
  endclocking
  default disable iff (!arst_n);
  // ********
  // bus ownership and command flow
  // ********
  // one turnaround cycle before the transceiver drives, so both ends never fight
  sequence turn_then_byte;
    phy_doe_n ##1 !phy_doe_n;
  endsequence
  chk_boot_status: assert property ($rose(arst_n) |-> ##[0:8] dir)
    else $error("no status byte after reset");
  chk_turn_cycle: assert property ($rose(dir) |-> turn_then_byte)
    else $error("status byte without turnaround");
  chk_phy_quiet: assert property (!dir |-> phy_doe_n)
    else $error("transceiver drives without owning the bus");
  chk_link_release: assert property (dir && $past(dir) |-> link_doe_n)
    else $error("link still drives while transceiver owns the bus");
  chk_status_short: assert property ($rose(dir) |-> ##[2:40] !dir)
    else $error("bus held by transceiver too long");
  chk_nxt_cause: assert property ($rose(nxt) |-> $past(data) != 8'h00 && !dir)
    else $error("nxt without a command byte");
  chk_cmd_held: assert property (!dir && !nxt && !stp && !link_doe_n &&
    link_dout != 8'h00 |=> $stable(link_dout) || dir)
    else $error("command byte changed before nxt");
  // first nonzero byte after idle is a command: only defined codes may appear
  chk_cmd_legal: assert property (!dir && !nxt && $past(data) == 8'h00 &&
    data != 8'h00 |-> data[7] || data[7:4] == 4'h4)
    else $error("undefined command byte");
  chk_stp_pulse: assert property (stp |=> !stp)
    else $error("stop longer than one cycle");
  chk_stp_idle: assert property (stp |-> link_dout == 8'h00)
    else $error("bus not idle with stop");
  chk_nxt_not_dir: assert property (nxt |-> !dir)
    else $error("receive active by dir and nxt");
endmodule

/* File: ucse_test.sv */
// self-checking bench of the ulpi command and status exchange
`timescale 1ns/100ps
module ucse_test;
  logic ref_clk = 1'b0;
  logic ulpi_clk = 1'b0;
  logic arst_n = 1'b0;
  ucse_pkg::ucse_phy_in_t pin = 13'h0000;
  logic req_valid = 1'b0;
  ucse_pkg::ucse_kind_t req_kind = ucse_pkg::UCSE_KIND_WR;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_data = 8'h00;
  logic req_ready, done, status_valid, rx_act, tx_raw, tx_byte_valid, reg_wr, reg_rd;
  logic tx_start, tx_end;
  logic [7:0] rd_data, status_byte, tx_byte, reg_addr, reg_wdata, reg_rdata;
  logic [7:0] last_stat, last_wr, last_ad, last_tx;
  logic [3:0] tx_pid;
  logic [7:0] n_start = 8'h00;
  logic [7:0] n_end = 8'h00;
  logic start_with_byte = 1'h0;
  int stat_n = 0;
  int failures = 0;
  int check_count = 0;
  always #50 ref_clk = ~ref_clk;
  always #3 ulpi_clk = ~ulpi_clk;
  // reads return the inverted address, so a wrong address shows in the data
  assign reg_rdata = ~reg_addr;
  // ********
  // instances and capture
  // ********
  ucse_ulpi_if ucse_ulpi_if_inst (.ulpi_clk(ulpi_clk));
  ucse_phy_end ucse_phy_end_inst (.ulpi(ucse_ulpi_if_inst), .arst_n,
    .linestate(pin.linestate), .session_ended_flag(pin.session_ended_flag),
    .session_valid_flag(pin.session_valid_flag), .a_device_supply_ok(pin.a_device_supply_ok),
    .rx_active(pin.rx_active), .rx_error(pin.rx_error), .host_disconnect(pin.host_disconnect),
    .cable_identification_level(pin.cable_identification_level), .b_valid(pin.b_valid),
    .alt_rise_en(pin.alt_rise_en), .alt_fall_en(pin.alt_fall_en), .low_power(pin.low_power),
    .reg_rdata, .tx_start, .tx_raw, .tx_pid, .tx_byte_valid, .tx_byte, .tx_end,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  ucse_link_end ucse_link_end_inst (.ulpi(ucse_ulpi_if_inst), .ref_clk, .arst_n, .req_valid,
    .req_kind, .req_addr, .req_data, .req_ready, .done, .rd_data, .status_valid,
    .status_byte, .rx_active(rx_act));
  ucse_monitor ucse_monitor_inst (.ulpi_clk, .arst_n, .dir(ucse_ulpi_if_inst.dir),
    .nxt(ucse_ulpi_if_inst.nxt), .stp(ucse_ulpi_if_inst.stp),
    .link_dout(ucse_ulpi_if_inst.link_dout), .link_doe_n(ucse_ulpi_if_inst.link_doe_n),
    .phy_dout(ucse_ulpi_if_inst.phy_dout), .phy_doe_n(ucse_ulpi_if_inst.phy_doe_n),
    .data(ucse_ulpi_if_inst.data));
  always @(posedge ulpi_clk)
  begin
    if (reg_wr)
      {last_ad, last_wr} <= {reg_addr, reg_wdata};
    if (reg_rd)
      last_ad <= reg_addr;
    if (tx_byte_valid)
      last_tx <= tx_byte;
    if (tx_start)
    begin
      n_start <= n_start + 8'h01;
      start_with_byte <= tx_byte_valid;
    end
    if (tx_end)
      n_end <= n_end + 8'h01;
  end
  always @(negedge ref_clk)
    if (status_valid)
    begin
      last_stat <= status_byte;
      stat_n <= stat_n + 1;
    end
  // ********
  // helpers
  // ********
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic req(input ucse_pkg::ucse_kind_t k, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(negedge ref_clk);
    {req_valid, req_kind, req_addr, req_data} = {1'b1, k, a, d};
    for (n = 0; n < 50 && !req_ready; n++)
      @(negedge ref_clk);
    @(negedge ref_clk);
    req_valid = 1'b0;
    for (n = 0; n < 80 && !done; n++)
      @(negedge ref_clk);
    if (!done)
    begin
      failures++;
      $display("mismatch at %0t: request never completed", $time);
      wrap_up;
    end
    check({7'h0, req_ready}, 8'h01);
  endtask
  task automatic exp_stat(input logic [7:0] exp);
    int n;
    for (n = 0; n < 60 && last_stat !== exp; n++)
      @(negedge ref_clk);
    check(last_stat, exp);
  endtask
  // ********
  // scenarios
  // ********
  // 3f is the last short address, 2f and c3 need the extended form
  task automatic t_regs;
    logic [7:0] ads [3] = '{8'h3F, 8'h2F, 8'hC3};
    for (int i = 0; i < 3; i++)
    begin
      req(ucse_pkg::UCSE_KIND_WR, ads[i], {ads[i][3:0], ads[i][7:4]});
      check(last_ad, ads[i]);
      check(last_wr, {ads[i][3:0], ads[i][7:4]});
      req(ucse_pkg::UCSE_KIND_RD, ads[i], 8'h00);
      check(last_ad, ads[i]);
      check(rd_data, ~ads[i]);
    end
  endtask
  task automatic t_tx;
    req(ucse_pkg::UCSE_KIND_PID, 8'h03, 8'h5A);
    check({4'h0, tx_pid}, 8'h03);
    check({7'h0, tx_raw}, 8'h00);
    check(last_tx, 8'h5A);
    check(n_start, 8'h01);
    check({7'h0, start_with_byte}, 8'h00);
    check(n_end, 8'h01);
    req(ucse_pkg::UCSE_KIND_RAW, 8'h00, 8'hC6);
    check({7'h0, tx_raw}, 8'h01);
    check(last_tx, 8'hC6);
    check(n_start, 8'h02);
    check({7'h0, start_with_byte}, 8'h01);
    check(n_end, 8'h02);
  endtask
  // index i walks every vbus, event and line state code at once
  task automatic t_fields;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge ref_clk);
      pin.session_ended_flag = (i == 0);
      pin.session_valid_flag = (i == 2);
      pin.a_device_supply_ok = (i == 3);
      pin.rx_active = i[0];
      pin.rx_error = (i == 3);
      pin.host_disconnect = (i == 2);
      pin.linestate = i[1:0];
      pin.cable_identification_level = i[0];
      exp_stat({1'b0, i[0], i[1:0], i[1:0], i[1:0]});
      // dir drops right after each status byte, so receive active is cleared again
      check({7'h0, rx_act}, 8'h00);
    end
  endtask
  task automatic t_alt_low;
    int n0;
    @(negedge ref_clk);
    pin.alt_rise_en = 1'b1;
    pin.b_valid = 1'b1;
    exp_stat(8'hFF);
    pin.low_power = 1'b1;
    pin.linestate = 2'h0;
    n0 = stat_n;
    repeat (10) @(negedge ref_clk);
    pin.linestate = 2'h3;
    pin.low_power = 1'b0;
    repeat (10) @(negedge ref_clk);
    check(stat_n[7:0], n0[7:0]);
    pin.alt_rise_en = 1'b0;
    pin.alt_fall_en = 1'b1;
    pin.b_valid = 1'b0;
    repeat (10) @(negedge ref_clk);
    check(stat_n[7:0], n0[7:0] + 8'h01);
    check(last_stat, 8'hFF);
  endtask
  initial
  begin
    pin.linestate = 2'h1;
    pin.session_ended_flag = 1'b1;
    pin.cable_identification_level = 1'b1;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    exp_stat(8'h41);
    t_regs;
    t_tx;
    t_fields;
    t_alt_low;
    wrap_up;
  end
endmodule
